// ### pps_pkg.sv
// Package for the pulse-per-second generator: timing constants.
// Assumes a 100 MHz system clock.
package pps_pkg;
    localparam int PPS_CLK_HZ = 100000000;
    localparam int PPS_LOW_MS = 1;
    localparam int PPS_PERIOD_MS = 1000;
    localparam int PPS_LOW_CYC = PPS_CLK_HZ / 1000 * PPS_LOW_MS;
    localparam int PPS_PERIOD_CYC = PPS_CLK_HZ / 1000 * PPS_PERIOD_MS;
    localparam int PPS_CNT_W = 27;
    localparam logic [26:0] PPS_CNT_RST = 27'h0;
endpackage

// ### pps_gen.sv
// Pulse-per-second generator: active 1 ms then idle 999 ms per second (low active unless rise_mark).
// Assumes sec_tick marks each second boundary from the receiver time base,
// and that fix_valid and time_valid are pins from another domain.
// How it works
// - No pulses while position solution invalid
// - Falling edge marks second boundary by default
// - Active 1 ms, idle 999 ms (low then high when falling), period one second
// - Setting selects rising or falling edge
// - Output valid only after lock and time
`timescale 1ns/100ps
module pps_gen
    import pps_pkg::*;
#(
    parameter int PERIOD_CYC = PPS_PERIOD_CYC,
    parameter int LOW_CYC = PPS_LOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sec_tick,
    input wire logic fix_valid,
    input wire logic time_valid,
    input wire logic rise_mark,
    output logic pps_out
);
    logic [2:0] fix_sync;
    logic [2:0] time_sync;
    logic fix_ok;
    logic time_ok;
    logic armed;
    logic [PPS_CNT_W-1:0] cnt;
    logic in_low;
    logic pps_valid;

    // Three stages; a change counts when the last two agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fix_sync <= 3'h0;
        end else begin
            fix_sync <= {fix_sync[1:0], fix_valid};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            time_sync <= 3'h0;
        end else begin
            time_sync <= {time_sync[1:0], time_valid};
        end
    end

    // Disagreeing stages keep the old level, so a glitch is dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fix_ok <= 1'b0;
        end else if (fix_sync[2] == fix_sync[1]) begin
            fix_ok <= fix_sync[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            time_ok <= 1'b0;
        end else if (time_sync[2] == time_sync[1]) begin
            time_ok <= time_sync[2];
        end
    end

    assign pps_valid = fix_ok && time_ok;

    // Start on a boundary only, so the first pulse is never short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (!pps_valid) begin
            armed <= 1'b0;
        end else if (sec_tick) begin
            armed <= 1'b1;
        end
    end

    // Boundary tick realigns the count; free-runs between ticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= PPS_CNT_RST;
        end else if (sec_tick) begin
            cnt <= PPS_CNT_RST;
        end else if (cnt == PPS_CNT_W'(PERIOD_CYC - 1)) begin
            cnt <= PPS_CNT_RST;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // The last count stands in for a missing tick, so the period holds
    always_comb begin
        in_low = 1'b0;
        if (sec_tick) begin
            in_low = 1'b1;
        end else if (armed && cnt == PPS_CNT_W'(PERIOD_CYC - 1)) begin
            in_low = 1'b1;
        end else if (armed && cnt < PPS_CNT_W'(LOW_CYC - 1)) begin
            in_low = 1'b1;
        end
    end

    // Registered output, so the edge lags the boundary by one clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pps_out <= 1'b1;
        end else if (!pps_valid || !(armed || sec_tick)) begin
            pps_out <= !rise_mark;
        end else if (in_low) begin
            pps_out <= rise_mark;
        end else begin
            pps_out <= !rise_mark;
        end
    end

    idle_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pps_valid |=> pps_out == !$past(rise_mark))
        else $error("pulse output left idle level while suppressed");

    edge_at_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        sec_tick && pps_valid && !rise_mark |=> !pps_out)
        else $error("no falling edge at the second boundary");

    rise_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        sec_tick && pps_valid && rise_mark |=> pps_out)
        else $error("no rising edge in rising mode");

    low_width_a: assert property (@(posedge clk) disable iff (!rst_n)
        armed && pps_valid && !sec_tick && !rise_mark &&
        cnt == PPS_CNT_W'(LOW_CYC - 1) |=> pps_out)
        else $error("low phase longer than one millisecond");

    no_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        !fix_ok |=> !armed)
        else $error("generator armed without a position fix");

    need_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        !time_ok |=> !armed)
        else $error("generator armed without valid time");

    wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        !sec_tick && cnt == PPS_CNT_W'(PERIOD_CYC - 1) |=> cnt == 0)
        else $error("period counter did not wrap at one second");

    arm_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(armed) |-> $past(sec_tick))
        else $error("pulses started off a second boundary");

    rise_width_a: assert property (@(posedge clk) disable iff (!rst_n)
        armed && pps_valid && !sec_tick && rise_mark &&
        cnt == PPS_CNT_W'(LOW_CYC - 1) |=> !pps_out)
        else $error("high phase too long in rising mode");

    count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        !sec_tick && cnt != PPS_CNT_W'(PERIOD_CYC - 1)
        |=> cnt == $past(cnt) + 1'b1)
        else $error("period counter skipped a step");

    cnt_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        cnt <= PPS_CNT_W'(PERIOD_CYC - 1))
        else $error("period counter beyond one second");

    tick_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        sec_tick |=> cnt == PPS_CNT_RST)
        else $error("boundary tick did not realign the count");

    period_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        armed && pps_valid && !sec_tick &&
        cnt == PPS_CNT_W'(PERIOD_CYC - 1) |=> pps_out == $past(rise_mark))
        else $error("no pulse at the free-running boundary");

    fix_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
        fix_sync[2] != fix_sync[1] |=> $stable(fix_ok))
        else $error("fix state moved on disagreeing stages");

    time_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
        time_sync[2] != time_sync[1] |=> $stable(time_ok))
        else $error("time state moved on disagreeing stages");

    tick_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        sec_tick && !pps_valid |=> pps_out == !$past(rise_mark))
        else $error("pulse produced without a valid solution");

    arm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        armed && pps_valid |=> armed)
        else $error("generator disarmed while still valid");

    idle_unarmed_a: assert property (@(posedge clk) disable iff (!rst_n)
        !armed && !sec_tick |=> pps_out == !$past(rise_mark))
        else $error("spurious edge before the first boundary");

    // Length of the active level; a tick starts a fresh pulse
    logic [PPS_CNT_W-1:0] act_run;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_run <= PPS_CNT_RST;
        end else if (sec_tick || pps_out != rise_mark) begin
            act_run <= PPS_CNT_RST;
        end else begin
            act_run <= act_run + 1'b1;
        end
    end

    act_width_a: assert property (@(posedge clk) disable iff (!rst_n)
        act_run <= PPS_CNT_W'(LOW_CYC))
        else $error("active level held longer than the pulse");

    first_pulse_c: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(armed));
    rise_mode_c: cover property (@(posedge clk) disable iff (!rst_n)
        armed && rise_mark && $rose(pps_out));
    lose_fix_c: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(armed));
    free_run_c: cover property (@(posedge clk) disable iff (!rst_n)
        armed && !sec_tick && cnt == PPS_CNT_W'(PERIOD_CYC - 1));
    early_tick_c: cover property (@(posedge clk) disable iff (!rst_n)
        armed && sec_tick && cnt != PPS_CNT_W'(PERIOD_CYC - 1));
endmodule

// ### pps_mon.sv
// Model of the equipment that receives the pulse: times each pulse.
// Assumes it is told which level is active; no reset of its own.
`timescale 1ns/100ps
module pps_mon (
    input wire logic clk,
    input wire logic pps_in,
    input wire logic rise_mark,
    output logic [7:0] act_len,
    output logic [7:0] n_edge
);
    logic [7:0] run;
    initial begin
        run = 8'h00;
        n_edge = 8'h00;
    end
    // Counts any active level at all, so spurious edges show up
    always @(posedge clk) begin
        run <= (pps_in === rise_mark) ? run + 8'h01 : 8'h00;
        if (pps_in === rise_mark && run == 8'h00) n_edge <= n_edge + 8'h01;
        if (pps_in !== rise_mark && run != 8'h00) act_len <= run;
    end
endmodule

// ### test_pps_gen.sv
// Testbench for the pulse-per-second generator with shortened counts.
// Assumes a 100 MHz clock; pps_mon stands for the far equipment.
`timescale 1ns/100ps
module test_pps_gen;
    localparam int PER = 20;
    localparam int LOW = 2;
    logic clk = 1'b0, rst_n = 1'b0, sec_tick = 1'b0, rise_mark = 1'b0;
    logic fix_valid = 1'b0, time_valid = 1'b0, pps_out;
    logic [7:0] act_len, n_edge, base;
    int n_mismatch = 0, samples_checked = 0;
    pps_gen #(.PERIOD_CYC(PER), .LOW_CYC(LOW)) i_dut (.clk(clk),
        .rst_n(rst_n), .sec_tick(sec_tick), .fix_valid(fix_valid),
        .time_valid(time_valid), .rise_mark(rise_mark), .pps_out(pps_out));
    pps_mon i_mon (.clk(clk), .pps_in(pps_out), .rise_mark(rise_mark),
        .act_len(act_len), .n_edge(n_edge));
    initial forever #5 clk = ~clk;
    function automatic logic [7:0] lvl(input logic on);
        return {7'h00, on ? rise_mark : !rise_mark};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    // One tick; an early tick must restart the pulse
    task automatic pulse(input logic on);
        @(posedge clk) #1 sec_tick = 1'b1;
        @(posedge clk) #1 sec_tick = 1'b0;
        chk({7'h00, pps_out}, lvl(on));
        repeat (LOW - 1) @(posedge clk);
        #1 chk({7'h00, pps_out}, lvl(on));
        @(posedge clk) #1 chk({7'h00, pps_out}, lvl(1'b0));
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'h648A6BCB));
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int m = 0; m < 2; m++) begin
            rise_mark = m[0];
            {fix_valid, time_valid} = 2'h1 << $urandom_range(1);
            pulse(1'b0);
            base = n_edge;
            pulse(1'b0);
            chk(n_edge, base);
            {fix_valid, time_valid} = 2'h3;
            repeat (6) @(posedge clk);
            repeat (2 + $urandom_range(2)) pulse(1'b1);
            // No tick here: the count must run on by itself
            repeat (PER - LOW) @(posedge clk);
            #1 chk({7'h00, pps_out}, lvl(1'b1));
            chk(act_len, 8'(LOW));
            {fix_valid, time_valid} = 2'h2 >> $urandom_range(1);
            repeat (PER) @(posedge clk);
            pulse(1'b0);
        end
        wrap_up;
    end
endmodule
